// ---- rtl/dsc_glue.v ----
`timescale 1ns/1ps
`include "dsc_map.vh"

module dsc_glue (
	input wire ref_clk,
	input wire sys_rst,
	input wire bus_reset,
	input wire [2:0] io_addr,
	input wire [7:0] io_wdata,
	input wire io_wr,
	input wire io_rd,
	output reg [7:0] io_rdata,
	input wire [4:0] chan_a_limits_n,
	input wire [4:0] chan_b_limits_n,
	output wire chan_a_pulse,
	output wire chan_a_direction_out,
	output wire [4:0] chan_a_windings,
	output wire chan_b_pulse,
	output wire chan_b_direction_out,
	output wire [4:0] chan_b_windings
);
	reg [7:0] ctrl_r;
	reg [8:0] tick_cnt_r;
	// Divider end count and monostable length, cut to their counter widths
	localparam [31:0] TICK_LAST_W = `DSC_TICK_CYC - 1;
	localparam [8:0] TICK_LAST = TICK_LAST_W[8:0];
	localparam [31:0] RST_PULSE_W = `DSC_RST_PULSE_CYC;
	localparam [6:0] RST_PULSE = RST_PULSE_W[6:0];
	wire base_rst;
	wire tick;
	wire data_command_addr;
	wire [1:0] chan_sel_n;
	wire [1:0] chan_rst;
	wire [9:0] lim_all_n;
	wire [15:0] stat_all;
	wire [15:0] data_all;
	wire [1:0] pulse_all;
	wire [1:0] dir_all;
	wire [9:0] wind_all;
	genvar ch;

	assign base_rst = sys_rst | bus_reset;
	assign data_command_addr = ctrl_r[`DSC_CTRL_RSEL];
	assign chan_sel_n = {ctrl_r[`DSC_CTRL_CSB], ctrl_r[`DSC_CTRL_CSA]};
	assign lim_all_n = {chan_b_limits_n, chan_a_limits_n};
	assign tick = (tick_cnt_r == TICK_LAST);

	// Control register: written and read back whole
	always @(posedge ref_clk) begin
		if (base_rst) begin
			ctrl_r <= `DSC_CTRL_RST;
		end else if (io_wr && io_addr == `DSC_OFS_CTRL) begin
			ctrl_r <= io_wdata;
		end
	end

	// Base step frequency divider shared by both channels
	always @(posedge ref_clk) begin
		if (base_rst || tick) begin
			tick_cnt_r <= 9'h000;
		end else begin
			tick_cnt_r <= tick_cnt_r + 9'h001;
		end
	end

	// Read data is registered one cycle after the read strobe
	always @(posedge ref_clk) begin
		if (base_rst) begin
			io_rdata <= 8'h00;
		end else if (io_rd) begin
			case (io_addr)
				`DSC_OFS_CTRL: io_rdata <= ctrl_r;
				`DSC_OFS_CHAN: begin
					if (!chan_sel_n[0]) begin
						io_rdata <= data_command_addr ? stat_all[7:0] : data_all[7:0];
					end else if (!chan_sel_n[1]) begin
						io_rdata <= data_command_addr ? stat_all[15:8] : data_all[15:8];
					end else begin
						io_rdata <= 8'h00;
					end
				end
				default: io_rdata <= 8'h00;
			endcase
		end
	end

	generate
		for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
			reg [23:0] data_sr_r;
			reg [7:0] rate_r;
			reg [12:0] ramp_r;
			reg [1:0] phase_code_r;
			reg alt_exc_r;
			reg run_r;
			reg stop_r;
			reg [3:0] mode_r;
			reg dir_r;
			reg [24:0] remain_r;
			reg [12:0] extra_r;
			reg [13:0] per_cnt_r;
			reg [3:0] step_idx_r;
			reg pulse_r;
			reg [6:0] mono_cnt_r;
			wire [2:0] ofs_rst = (ch == 0) ? `DSC_OFS_RST_A : `DSC_OFS_RST_B;
			wire [4:0] lim_n = lim_all_n[ch*5 +: 5];
			wire sel = io_addr == `DSC_OFS_CHAN && !chan_sel_n[ch];
			wire wr_cmd = io_wr && sel && data_command_addr;
			wire wr_data = io_wr && sel && !data_command_addr;
			wire [3:0] cmd = io_wdata[3:0];
			wire cmd_dir = io_wdata[`DSC_CMD_DIR];
			wire blocked = cmd_dir ? !lim_n[`DSC_LIM_OUT_R] : !lim_n[`DSC_LIM_OUT_F];
			wire outer_hit = dir_r ? !lim_n[`DSC_LIM_OUT_R] : !lim_n[`DSC_LIM_OUT_F];
			wire slow_hit = dir_r ? !lim_n[`DSC_LIM_SLOW_R] : !lim_n[`DSC_LIM_SLOW_F];
			wire is_motion = cmd == `DSC_M_STEP || cmd == `DSC_M_ACCEL || cmd == `DSC_M_CONST ||
				cmd == `DSC_M_OUTER || cmd == `DSC_M_HSLIM || cmd == `DSC_M_BASE;
			wire counted = mode_r == `DSC_M_STEP || mode_r == `DSC_M_ACCEL || mode_r == `DSC_M_CONST;
			wire [13:0] period = {6'h00, rate_r} + {1'b0, extra_r};
			wire [3:0] n_steps = ((phase_code_r == 2'h0) ? 4'h3 : (phase_code_r == 2'h1) ? 4'h4 : 4'h5) << alt_exc_r;
			wire [3:0] last_idx = n_steps - 4'h1;
			wire [12:0] ramp_in = data_sr_r[12:0];

			// Reset monostable: any write to the trigger offset starts it
			always @(posedge ref_clk) begin
				if (base_rst) begin
					mono_cnt_r <= 7'h00;
				end else if (io_wr && io_addr == ofs_rst) begin
					mono_cnt_r <= RST_PULSE;
				end else if (mono_cnt_r != 7'h00) begin
					mono_cnt_r <= mono_cnt_r - 7'h01;
				end
			end
			assign chan_rst[ch] = base_rst || mono_cnt_r != 7'h00;

			// Command decode and step engine
			always @(posedge ref_clk) begin
				if (chan_rst[ch]) begin
					data_sr_r <= 24'h000000;
					rate_r <= `DSC_RATE_RST;
					ramp_r <= `DSC_RAMP_MIN;
					phase_code_r <= 2'h1;
					alt_exc_r <= 1'b0;
					run_r <= 1'b0;
					stop_r <= 1'b0;
					mode_r <= `DSC_M_ESTOP;
					dir_r <= 1'b0;
					remain_r <= 25'h0000000;
					extra_r <= 13'h0000;
					per_cnt_r <= 14'h0000;
					step_idx_r <= 4'h0;
					pulse_r <= 1'b0;
				end else begin
					if (tick) begin
						pulse_r <= 1'b0;
					end
					if (wr_data) begin
						data_sr_r <= {data_sr_r[15:0], io_wdata};
					end
					if (wr_cmd) begin
						if (cmd == `DSC_M_ESTOP) begin
							run_r <= 1'b0;
						end else if (cmd == `DSC_M_DSTOP) begin
							stop_r <= run_r;
						end else if (is_motion && !run_r && !blocked) begin
							run_r <= 1'b1;
							stop_r <= 1'b0;
							mode_r <= cmd;
							dir_r <= cmd_dir;
							per_cnt_r <= 14'h0000;
							extra_r <= (cmd == `DSC_M_ACCEL || cmd == `DSC_M_HSLIM) ? ramp_r : 13'h0000;
							if (cmd == `DSC_M_STEP) begin
								remain_r <= 25'h0000001;
							end else begin
								remain_r <= {1'b0, data_sr_r} + 25'h0000001;
							end
						end else if (cmd == `DSC_M_DIV) begin
							rate_r <= (data_sr_r[7:0] == 8'h00) ? 8'h01 : data_sr_r[7:0];
						end else if (cmd == `DSC_M_INIT) begin
							phase_code_r <= (io_wdata[`DSC_CMD_PH_HI:`DSC_CMD_PH_LO] == 2'h3) ? 2'h2 :
								io_wdata[`DSC_CMD_PH_HI:`DSC_CMD_PH_LO];
							alt_exc_r <= io_wdata[`DSC_CMD_ALT];
							step_idx_r <= 4'h0;
							ramp_r <= (ramp_in < `DSC_RAMP_MIN) ? `DSC_RAMP_MIN :
								(ramp_in > `DSC_RAMP_MAX) ? `DSC_RAMP_MAX : ramp_in;
						end
					end else if (run_r) begin
						if (outer_hit) begin
							run_r <= 1'b0;
						end else if (mode_r == `DSC_M_BASE && !lim_n[`DSC_LIM_BASE]) begin
							run_r <= 1'b0;
						end else if (tick) begin
							if (slow_hit && !counted) begin
								stop_r <= 1'b1;
							end
							if (per_cnt_r + 14'h0001 >= period) begin
								per_cnt_r <= 14'h0000;
								pulse_r <= 1'b1;
								if (dir_r) begin
									step_idx_r <= (step_idx_r == 4'h0) ? last_idx : step_idx_r - 4'h1;
								end else begin
									step_idx_r <= (step_idx_r >= last_idx) ? 4'h0 : step_idx_r + 4'h1;
								end
								if (counted) begin
									remain_r <= remain_r - 25'h0000001;
									if (remain_r == 25'h0000001) begin
										run_r <= 1'b0;
									end
								end
								if (stop_r) begin
									if (extra_r >= ramp_r) begin
										run_r <= 1'b0;
									end else begin
										extra_r <= extra_r + 13'h0001;
									end
								end else if (mode_r == `DSC_M_ACCEL && remain_r <= {12'h000, ramp_r}) begin
									extra_r <= (extra_r >= ramp_r) ? ramp_r : extra_r + 13'h0001;
								end else if (extra_r != 13'h0000) begin
									extra_r <= extra_r - 13'h0001;
								end
							end else begin
								per_cnt_r <= per_cnt_r + 14'h0001;
							end
						end
					end
				end
			end

			assign stat_all[ch*8 +: 8] = {run_r, dir_r, stop_r, ~lim_n};
			assign data_all[ch*8 +: 8] = remain_r[7:0];
			assign pulse_all[ch] = pulse_r;
			assign dir_all[ch] = dir_r;

			dsc_winding u_wind (
				.ref_clk(ref_clk),
				.rst(chan_rst[ch]),
				.phase_code(phase_code_r),
				.alt_exc(alt_exc_r),
				.step_idx(step_idx_r),
				.winding_out(wind_all[ch*5 +: 5])
			);
		end
	endgenerate

	assign chan_a_pulse = pulse_all[0];
	assign chan_a_direction_out = dir_all[0];
	assign chan_a_windings = wind_all[4:0];
	assign chan_b_pulse = pulse_all[1];
	assign chan_b_direction_out = dir_all[1];
	assign chan_b_windings = wind_all[9:5];
endmodule // dsc_glue

// ---- rtl/dsc_map.vh ----
`ifndef DSC_MAP_VH
`define DSC_MAP_VH

// Host I/O offsets relative to the board base address
`define DSC_OFS_CHAN 3'h0
`define DSC_OFS_CTRL 3'h2
`define DSC_OFS_RST_A 3'h3
`define DSC_OFS_RST_B 3'h4

// Board control register fields and reset value
`define DSC_CTRL_RSEL 0
`define DSC_CTRL_CSA 1
`define DSC_CTRL_CSB 2
`define DSC_CTRL_RST 8'h06

// Command byte layout
`define DSC_CMD_DIR 4
`define DSC_CMD_PH_LO 4
`define DSC_CMD_PH_HI 5
`define DSC_CMD_ALT 6

// Command codes
`define DSC_M_ESTOP 4'h0
`define DSC_M_DSTOP 4'h1
`define DSC_M_STEP 4'h2
`define DSC_M_ACCEL 4'h3
`define DSC_M_CONST 4'h4
`define DSC_M_OUTER 4'h5
`define DSC_M_HSLIM 4'h6
`define DSC_M_BASE 4'h7
`define DSC_M_DIV 4'hA
`define DSC_M_INIT 4'hC

// Limit input bit positions, all active low
`define DSC_LIM_OUT_F 0
`define DSC_LIM_OUT_R 1
`define DSC_LIM_SLOW_F 2
`define DSC_LIM_SLOW_R 3
`define DSC_LIM_BASE 4

// Reset values and ramp bounds
`define DSC_RATE_RST 8'h14
`define DSC_RAMP_MIN 13'h0004
`define DSC_RAMP_MAX 13'h1FE0

// Timing
`define DSC_CLK_KHZ 25000
`define DSC_BASE_FREQ_KHZ 100
`define DSC_TICK_CYC (`DSC_CLK_KHZ / `DSC_BASE_FREQ_KHZ)
`define DSC_RST_PULSE_NS 2500
`define DSC_RST_PULSE_CYC ((`DSC_RST_PULSE_NS * `DSC_CLK_KHZ + 999999) / 1000000)

`endif

// ---- rtl/dsc_winding.v ----
`timescale 1ns/1ps
`include "dsc_map.vh"

module dsc_winding (
	input wire ref_clk,
	input wire rst,
	input wire [1:0] phase_code,
	input wire alt_exc,
	input wire [3:0] step_idx,
	output reg [4:0] winding_out
);
	wire [3:0] n_ph;
	wire [3:0] k;
	wire [3:0] span;
	wire [4:0] pat;
	genvar w;

	// Phase count is 3, 4 or 5; half-step modes walk the base winding every second step
	assign n_ph = (phase_code == 2'h0) ? 4'h3 : (phase_code == 2'h1) ? 4'h4 : 4'h5;
	assign k = alt_exc ? {1'b0, step_idx[3:1]} : step_idx;
	assign span = !alt_exc ? 4'h2 : (n_ph == 4'h5) ? (step_idx[0] ? 4'h3 : 4'h2) : (step_idx[0] ? 4'h2 : 4'h1);

	// Winding w is on when it lies within span windings after the base winding
	generate
		for (w = 0; w < 5; w = w + 1) begin : g_wind
			wire [3:0] wv = w;
			wire [4:0] raw = {1'b0, wv} + {1'b0, n_ph} - {1'b0, k};
			wire [4:0] d = (raw >= {1'b0, n_ph}) ? raw - {1'b0, n_ph} : raw;
			assign pat[w] = (wv < n_ph) && (d < {1'b0, span});
		end
	endgenerate

	// Windings are registered so the pins never glitch
	always @(posedge ref_clk) begin
		if (rst) begin
			winding_out <= 5'h00;
		end else begin
			winding_out <= pat;
		end
	end
endmodule // dsc_winding

// ---- sim/dsc_glue_sva.sv ----
`timescale 1ns/1ps
module dsc_glue_sva (
	input wire ref_clk,
	input wire sys_rst,
	input wire bus_reset,
	input wire [2:0] io_addr,
	input wire [7:0] io_wdata,
	input wire io_wr,
	input wire io_rd,
	input wire [7:0] io_rdata,
	input wire [4:0] chan_a_limits_n,
	input wire chan_a_pulse,
	input wire chan_a_direction_out,
	input wire [4:0] chan_a_windings,
	input wire chan_b_pulse
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);
	// Control write, one idle edge, then control read
	sequence ctrl_wr_rd;
		io_wr && io_addr == 3'h2 ##1 !io_wr && !bus_reset ##1 io_rd && io_addr == 3'h2 && !bus_reset;
	endsequence
	// Step pulse leaving low
	sequence step_start;
		$rose(chan_a_pulse);
	endsequence
	bus_rst_quiet_a: assert property (bus_reset |=> !chan_a_pulse && !chan_b_pulse && io_rdata == 8'h00)
		else $error("bus reset left outputs active");
	ctrl_readback_a: assert property (ctrl_wr_rd |=> io_rdata == $past(io_wdata, 3))
		else $error("control read differs from write");
	rdata_hold_a: assert property (!io_rd && !$past(io_rd) && !bus_reset |=> $stable(io_rdata))
		else $error("read data moved without a read");
	chan_a_rst_a: assert property (io_wr && io_addr == 3'h3 |-> ##2 (!chan_a_pulse) [*8])
		else $error("channel A pulsed during reset");
	chan_b_rst_a: assert property (io_wr && io_addr == 3'h4 |-> ##2 (!chan_b_pulse) [*8])
		else $error("channel B pulsed during reset");
	pulse_width_a: assert property (step_start |-> chan_a_pulse [*8])
		else $error("step pulse too short");
	wind_step_a: assert property (step_start |-> ##[1:2] (chan_a_windings != $past(chan_a_windings)))
		else $error("windings did not advance");
	limit_stop_a: assert property (!chan_a_limits_n[0] && !chan_a_direction_out |=> !$rose(chan_a_pulse))
		else $error("step into active outer limit");
endmodule // dsc_glue_sva
bind dsc_glue dsc_glue_sva u_sva (.ref_clk(ref_clk), .sys_rst(sys_rst), .bus_reset(bus_reset),
	.io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata),
	.chan_a_limits_n(chan_a_limits_n), .chan_a_pulse(chan_a_pulse), .chan_a_direction_out(chan_a_direction_out),
	.chan_a_windings(chan_a_windings), .chan_b_pulse(chan_b_pulse));

// ---- sim/dsc_host_model.sv ----
`timescale 1ns/1ps
module dsc_host_model (
	input wire ref_clk,
	output reg [2:0] io_addr,
	output reg [7:0] io_wdata,
	output reg io_wr,
	output reg io_rd,
	input wire [7:0] io_rdata
);
	// Idle bus
	initial begin
		io_addr = 3'h0;
		io_wdata = 8'h00;
		io_wr = 1'b0;
		io_rd = 1'b0;
	end
	// One-cycle write; data inverted afterwards so stale bytes never look valid
	task wr(input [2:0] a, input [7:0] d);
		begin
			@(negedge ref_clk);
			io_addr = a;
			io_wdata = d;
			io_wr = 1'b1;
			@(negedge ref_clk);
			io_wr = 1'b0;
			io_wdata = ~d;
		end
	endtask
	// One-cycle read, data taken once settled
	task rd(input [2:0] a, output [7:0] d);
		begin
			@(negedge ref_clk);
			io_addr = a;
			io_rd = 1'b1;
			@(negedge ref_clk);
			io_rd = 1'b0;
			@(negedge ref_clk);
			d = io_rdata;
		end
	endtask
	// Load a count and start a move on channel A or B; only one select is ever low
	task move(input [23:0] n, input [7:0] cmd, input raw, input b);
		reg [23:0] c;
		reg [7:0] sel;
		begin
			c = raw ? n : n - 24'h1;
			sel = b ? 8'h02 : 8'h04;
			if (raw || n > 24'h1) begin
				wr(3'h2, sel);
				wr(3'h0, c[23:16]);
				wr(3'h0, c[15:8]);
				wr(3'h0, c[7:0]);
				wr(3'h2, sel | 8'h01);
				wr(3'h0, cmd);
			end else if (n == 24'h1) begin
				wr(3'h2, sel | 8'h01);
				wr(3'h0, {cmd[7:4], 4'h2});
			end
		end
	endtask
endmodule // dsc_host_model

// ---- sim/test_dual_stepper_channel_glue.sv ----
`timescale 1ns/1ps
module test_dual_stepper_channel_glue;
	reg ref_clk = 1'b0;
	reg sys_rst = 1'b1;
	reg bus_reset = 1'b0;
	reg [4:0] lim_a = 5'h1F;
	reg [4:0] lim_b = 5'h1F;
	wire [2:0] io_addr;
	wire [7:0] io_wdata;
	wire [7:0] io_rdata;
	wire io_wr;
	wire io_rd;
	wire pulse_a;
	wire dir_a;
	wire pulse_b;
	wire dir_b;
	wire [4:0] wind_a;
	wire [4:0] wind_b;
	reg [7:0] rv;
	integer bad_count = 0;
	integer compares = 0;
	integer npulse = 0;
	integer npulse_b = 0;
	integer cyc = 0;
	integer last_a = 0;
	integer last_b = 0;
	integer gap_a = 0;
	integer gap_b = 0;
	// 25 MHz clock
	initial begin
		forever #20 ref_clk = ~ref_clk;
	end
	dsc_host_model host (.ref_clk(ref_clk), .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr),
		.io_rd(io_rd), .io_rdata(io_rdata));
	dsc_glue DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .bus_reset(bus_reset), .io_addr(io_addr),
		.io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata), .chan_a_limits_n(lim_a),
		.chan_b_limits_n(lim_b), .chan_a_pulse(pulse_a), .chan_a_direction_out(dir_a),
		.chan_a_windings(wind_a), .chan_b_pulse(pulse_b), .chan_b_direction_out(dir_b),
		.chan_b_windings(wind_b));
	// Cycle count, bumped before the design's outputs settle in the same edge
	always @(posedge ref_clk) cyc = cyc + 1;
	// Count steps per channel and keep the spacing of the latest two
	always @(posedge pulse_a) begin
		npulse = npulse + 1;
		gap_a = cyc - last_a;
		last_a = cyc;
	end
	always @(posedge pulse_b) begin
		npulse_b = npulse_b + 1;
		gap_b = cyc - last_b;
		last_b = cyc;
	end
	task chk8(input [8*14:1] what, input [7:0] exp, input [7:0] got);
		begin
			compares = compares + 1;
			if (got !== exp) begin
				bad_count = bad_count + 1;
				$display("BAD %0s expected %h seen %h", what, exp, got);
			end
		end
	endtask
	task chkn(input [8*14:1] what, input integer exp, input integer got);
		begin
			compares = compares + 1;
			if (got != exp) begin
				bad_count = bad_count + 1;
				$display("BAD %0s expected %0d seen %0d", what, exp, got);
			end
		end
	endtask
	// Issue a move, then leave one slot a little over a rate-20 step period per slot
	task run(input [23:0] n, input [7:0] cmd, input raw, input b, input integer slots);
		begin
			npulse = 0;
			npulse_b = 0;
			host.move(n, cmd, raw, b);
			repeat (slots * 5200) @(negedge ref_clk);
		end
	endtask
	task tally_and_finish;
		begin
			$display("Comparisons %0d mismatches %0d", compares, bad_count);
			if (bad_count == 0 && compares > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	// Hang guard
	initial begin
		repeat (95000) @(posedge ref_clk);
		bad_count = bad_count + 1;
		tally_and_finish;
	end
	// Test sequence
	initial begin
		repeat (20) @(negedge ref_clk);
		sys_rst = 1'b0;
		host.rd(3'h2, rv);
		chk8("ctrl reset", 8'h06, rv);
		host.rd(3'h0, rv);
		chk8("unselected", 8'h00, rv);
		host.rd(3'h7, rv);
		chk8("unmapped", 8'h00, rv);
		host.wr(3'h2, 8'h05);
		host.rd(3'h2, rv);
		chk8("ctrl readback", 8'h05, rv);
		host.wr(3'h3, 8'h00);
		host.wr(3'h4, 8'h00);
		repeat (70) @(negedge ref_clk);
		run(24'h0, 8'h04, 1'b1, 1'b0, 2);
		chkn("pulses A", 1, npulse);
		run(24'h1, 8'h04, 1'b1, 1'b0, 3);
		chkn("pulses A", 2, npulse);
		chkn("period A", 5000, gap_a);
		run(24'h2, 8'h04, 1'b0, 1'b0, 3);
		chkn("pulses A", 2, npulse);
		run(24'h1, 8'h04, 1'b0, 1'b0, 2);
		chkn("pulses A", 1, npulse);
		lim_a = 5'h1E;
		run(24'h0, 8'h04, 1'b1, 1'b0, 1);
		chkn("pulses A", 0, npulse);
		run(24'h0, 8'h14, 1'b1, 1'b0, 2);
		chkn("pulses A", 1, npulse);
		chk8("direction", 8'h01, {7'h00, dir_a});
		chk8("wind A", 8'h06, {3'h0, wind_a});
		// Remaining count read back, then emergency stop before the first step
		host.move(24'h3, 8'h14, 1'b1, 1'b0);
		host.wr(3'h2, 8'h04);
		host.rd(3'h0, rv);
		chk8("data A", 8'h04, rv);
		host.wr(3'h2, 8'h05);
		host.wr(3'h0, 8'h00);
		host.rd(3'h0, rv);
		chk8("status A", 8'h41, rv);
		// Channel B: rate 2, then 4-phase half step
		host.wr(3'h2, 8'h02);
		host.wr(3'h0, 8'h02);
		host.wr(3'h2, 8'h03);
		chk8("wind B full", 8'h03, {3'h0, wind_b});
		host.wr(3'h0, 8'h0A);
		host.wr(3'h0, 8'h5C);
		repeat (2) @(negedge ref_clk);
		chk8("wind B half", 8'h01, {3'h0, wind_b});
		run(24'h3, 8'h04, 1'b1, 1'b1, 1);
		chkn("pulses B", 4, npulse_b);
		chkn("period B", 500, gap_b);
		chk8("wind B step5", 8'h04, {3'h0, wind_b});
		run(24'h4, 8'h03, 1'b1, 1'b1, 2);
		chkn("pulses B", 5, npulse_b);
		// Base point, outer limit and monostable reset on channel B
		host.wr(3'h0, 8'h07);
		host.rd(3'h0, rv);
		chk8("status B run", 8'h80, rv);
		lim_b = 5'h0F;
		host.rd(3'h0, rv);
		chk8("status B base", 8'h10, rv);
		lim_b = 5'h1F;
		host.wr(3'h0, 8'h15);
		lim_b = 5'h1D;
		host.rd(3'h0, rv);
		chk8("status B outer", 8'h42, rv);
		chk8("dir B", 8'h01, {7'h00, dir_b});
		host.wr(3'h0, 8'h15);
		host.rd(3'h0, rv);
		chk8("status B block", 8'h42, rv);
		host.wr(3'h0, 8'h05);
		host.rd(3'h0, rv);
		chk8("status B fwd", 8'h82, rv);
		host.wr(3'h4, 8'h00);
		repeat (70) @(negedge ref_clk);
		host.rd(3'h0, rv);
		chk8("status B reset", 8'h02, rv);
		chk8("wind B reset", 8'h03, {3'h0, wind_b});
		bus_reset = 1'b1;
		@(negedge ref_clk);
		bus_reset = 1'b0;
		host.rd(3'h2, rv);
		chk8("bus reset", 8'h06, rv);
		tally_and_finish;
	end
endmodule // test_dual_stepper_channel_glue
